// ===== src/mtrl_lookup.sv
`timescale 1ns/1ps
module mtrl_lookup #(
   parameter int PHYS_ADDR_W = 52
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Special-register access
   input wire logic reg_valid,
   input wire mtrl_pkg::mtrl_reg_req_s reg_req,
   output logic [63:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_fault,
   // Lookup request
   input wire logic lookup_valid,
   input wire logic [51:0] lookup_addr,
   // Lookup answer
   output logic result_valid,
   output mtrl_pkg::mtrl_result_s result
);
   logic [63:0] fixed_regs [mtrl_pkg::NUM_FIXED];
   logic [63:0] base_regs [mtrl_pkg::NUM_VAR];
   logic [63:0] mask_regs [mtrl_pkg::NUM_VAR];
   logic [63:0] default_type_control;
   logic [51:0] addr_mask;
   logic [51:0] eff_addr;
   logic [39:0] page_addr;
   logic [mtrl_pkg::NUM_VAR-1:0] var_hit;
   logic [2:0] var_type [mtrl_pkg::NUM_VAR];
   logic [3:0] fixed_sel;
   logic [2:0] fixed_byte;
   logic [7:0] fixed_field;
   logic in_fixed;
   logic any_var;
   logic [2:0] var_resolved;
   mtrl_pkg::mtrl_result_s next_result;
   logic [63:0] next_rdata;
   logic next_fault;
   logic [4:0] widx;
   logic [2:0] vsel;

   // Implemented physical address bits
   assign addr_mask = (PHYS_ADDR_W >= mtrl_pkg::ADDR_W) ? {52{1'b1}} :
      ((52'h1 << PHYS_ADDR_W) - 52'h1);
   assign eff_addr = lookup_addr & addr_mask;
   assign page_addr = eff_addr[mtrl_pkg::FIELD_MSB:mtrl_pkg::FIELD_LSB];
   assign widx = reg_req.index;
   assign vsel = widx[3:1];

   // Variable range comparators
   genvar g;
   generate
      for (g = 0; g < mtrl_pkg::NUM_VAR; g++) begin : g_var
         mtrl_var_match u_match (
            .range_base_field(base_regs[g]),
            .range_mask_field(mask_regs[g]),
            .page_addr(page_addr),
            .hit(var_hit[g]),
            .mem_type(var_type[g])
         );
      end
   endgenerate

   // Fixed register and field select from address bits 19:12
   always_comb begin
      in_fixed = eff_addr < mtrl_pkg::LIMIT_1M;
      if (eff_addr[19:0] < mtrl_pkg::LIMIT_64K) begin
         fixed_sel = 4'h0;
         fixed_byte = eff_addr[18:16];
      end else if (eff_addr[19:0] < mtrl_pkg::LIMIT_16K) begin
         fixed_sel = 4'h1 + {3'h0, eff_addr[17]};
         fixed_byte = eff_addr[16:14];
      end else begin
         fixed_sel = 4'h3 + {1'b0, eff_addr[17:15]};
         fixed_byte = eff_addr[14:12];
      end
      fixed_field = fixed_regs[fixed_sel][{fixed_byte, 3'h0} +: 8];
   end

   // Overlapping variable ranges
   always_comb begin
      logic saw_uc;
      logic saw_wt;
      logic saw_other;
      logic saw_odd;
      logic [2:0] first;
      logic have;
      saw_uc = 1'b0;
      saw_wt = 1'b0;
      saw_other = 1'b0;
      saw_odd = 1'b0;
      first = mtrl_pkg::TYPE_UC;
      have = 1'b0;
      for (int i = 0; i < mtrl_pkg::NUM_VAR; i++) begin
         if (var_hit[i]) begin
            if (!have) begin
               first = var_type[i];
               have = 1'b1;
            end else if (var_type[i] != first) begin
               saw_other = 1'b1;
            end
            if (var_type[i] == mtrl_pkg::TYPE_UC) begin
               saw_uc = 1'b1;
            end
            if (var_type[i] == mtrl_pkg::TYPE_WT) begin
               saw_wt = 1'b1;
            end
            // Any type beside WT and WB makes a mix undefined
            if (var_type[i] != mtrl_pkg::TYPE_WT && var_type[i] != mtrl_pkg::TYPE_WB) begin
               saw_odd = 1'b1;
            end
         end
      end
      any_var = have;
      // Mixed types other than UC or WT/WB fall back to UC
      if (saw_uc) begin
         var_resolved = mtrl_pkg::TYPE_UC;
      end else if (!saw_other) begin
         var_resolved = first;
      end else if (saw_wt && !saw_odd) begin
         var_resolved = mtrl_pkg::TYPE_WT;
      end else begin
         var_resolved = mtrl_pkg::TYPE_UC;
      end
   end

   // Final resolution
   always_comb begin
      next_result = '0;
      // Extended attributes independent of the global enable
      if (in_fixed && default_type_control[mtrl_pkg::FE_BIT]) begin
         next_result.read_to_memory_attr = fixed_field[mtrl_pkg::EXT_RD_BIT];
         next_result.write_to_memory_attr = fixed_field[mtrl_pkg::EXT_WR_BIT];
      end
      if (!default_type_control[mtrl_pkg::EN_BIT]) begin
         next_result.mem_type = mtrl_pkg::TYPE_UC;
      end else if (in_fixed && default_type_control[mtrl_pkg::FE_BIT]) begin
         next_result.mem_type = fixed_field[2:0];
         next_result.fixed_hit = 1'b1;
      end else if (any_var) begin
         next_result.mem_type = var_resolved;
         next_result.var_hit = 1'b1;
      end else begin
         next_result.mem_type = default_type_control[2:0];
      end
   end

   // Register read decode
   always_comb begin
      next_rdata = mtrl_pkg::RESET_VALUE;
      next_fault = 1'b0;
      if (widx <= mtrl_pkg::IDX_FIX4K_LAST) begin
         next_rdata = fixed_regs[widx[3:0]];
      end else if (widx == mtrl_pkg::IDX_DEFTYPE) begin
         next_rdata = default_type_control;
      end else if (widx >= mtrl_pkg::IDX_VAR_FIRST) begin
         next_rdata = widx[0] ? mask_regs[vsel] : base_regs[vsel];
      end else begin
         next_fault = 1'b1;
      end
   end

   // Fixed register writes
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < mtrl_pkg::NUM_FIXED; i++) begin
            fixed_regs[i] <= mtrl_pkg::RESET_VALUE;
         end
      end else if (reg_valid && reg_req.write && widx <= mtrl_pkg::IDX_FIX4K_LAST) begin
         fixed_regs[widx[3:0]] <= reg_req.data & mtrl_pkg::MASK_FIX;
      end
   end

   // Default type register writes
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         default_type_control <= mtrl_pkg::RESET_VALUE;
      end else if (reg_valid && reg_req.write && widx == mtrl_pkg::IDX_DEFTYPE) begin
         default_type_control <= reg_req.data & mtrl_pkg::MASK_DEFTYPE;
      end
   end

   // Variable pair writes
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < mtrl_pkg::NUM_VAR; i++) begin
            base_regs[i] <= mtrl_pkg::RESET_VALUE;
            mask_regs[i] <= mtrl_pkg::RESET_VALUE;
         end
      end else if (reg_valid && reg_req.write && widx >= mtrl_pkg::IDX_VAR_FIRST) begin
         if (widx[0]) begin
            mask_regs[vsel] <= reg_req.data & mtrl_pkg::MASK_MASK;
         end else begin
            base_regs[vsel] <= reg_req.data & mtrl_pkg::MASK_BASE;
         end
      end
   end

   // Register answer
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= mtrl_pkg::RESET_VALUE;
         reg_rvalid <= 1'b0;
         reg_fault <= 1'b0;
      end else begin
         reg_rvalid <= reg_valid;
         reg_fault <= reg_valid && next_fault;
         reg_rdata <= (reg_valid && !reg_req.write) ? next_rdata : mtrl_pkg::RESET_VALUE;
      end
   end

   // Lookup answer, one cycle after the request
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         result_valid <= 1'b0;
         result <= '0;
      end else begin
         result_valid <= lookup_valid;
         result <= lookup_valid ? next_result : '0;
      end
   end
endmodule

// ===== src/mtrl_pkg.sv
package mtrl_pkg;
   // Register indices of the special-register window
   localparam logic [4:0] IDX_FIX64K = 5'h00;
   localparam logic [4:0] IDX_FIX16K_FIRST = 5'h01;
   localparam logic [4:0] IDX_FIX4K_FIRST = 5'h03;
   localparam logic [4:0] IDX_FIX4K_LAST = 5'h0A;
   localparam logic [4:0] IDX_DEFTYPE = 5'h0B;
   localparam logic [4:0] IDX_VAR_FIRST = 5'h10;
   localparam int NUM_FIXED = 11;
   localparam int NUM_VAR = 8;
   localparam int ADDR_W = 52;
   localparam int PAGE_SHIFT = 12;
   // Memory type codes
   localparam logic [2:0] TYPE_UC = 3'h0;
   localparam logic [2:0] TYPE_WC = 3'h1;
   localparam logic [2:0] TYPE_WT = 3'h4;
   localparam logic [2:0] TYPE_WP = 3'h5;
   localparam logic [2:0] TYPE_WB = 3'h6;
   // Field positions
   localparam int TYPE_LSB = 0;
   localparam int TYPE_MSB = 7;
   localparam int EXT_RD_BIT = 4;
   localparam int EXT_WR_BIT = 3;
   localparam int FE_BIT = 10;
   localparam int EN_BIT = 11;
   localparam int VALID_BIT = 11;
   localparam int FIELD_MSB = 51;
   localparam int FIELD_LSB = 12;
   // Fixed region limits (address bits 19:12 form the 4K page)
   localparam logic [19:0] LIMIT_64K = 20'h8_0000;
   localparam logic [19:0] LIMIT_16K = 20'hC_0000;
   localparam logic [ADDR_W-1:0] LIMIT_1M = 52'h0_0000_0010_0000;
   localparam logic [63:0] RESET_VALUE = 64'h0000_0000_0000_0000;
   // Register write masks
   localparam logic [63:0] MASK_FIX = 64'h1F1F_1F1F_1F1F_1F1F;
   localparam logic [63:0] MASK_STD_TYPE = 64'h0000_0000_0000_0007;
   localparam logic [63:0] MASK_DEFTYPE = 64'h0000_0000_0000_0C07;
   localparam logic [63:0] MASK_BASE = 64'h000F_FFFF_FFFF_F007;
   localparam logic [63:0] MASK_MASK = 64'h000F_FFFF_FFFF_F800;

   typedef struct packed {
      logic       write;
      logic [4:0] index;
      logic [63:0] data;
   } mtrl_reg_req_s;

   typedef struct packed {
      logic [2:0] mem_type;
      logic       read_to_memory_attr;
      logic       write_to_memory_attr;
      logic       fixed_hit;
      logic       var_hit;
   } mtrl_result_s;
endpackage

// ===== src/mtrl_var_match.sv
`timescale 1ns/1ps
module mtrl_var_match (
   // Range pair
   input wire logic [63:0] range_base_field,
   input wire logic [63:0] range_mask_field,
   // Lookup address, page bits only
   input wire logic [39:0] page_addr,
   // Result
   output logic hit,
   output logic [2:0] mem_type
);
   logic [39:0] base_page;
   logic [39:0] mask_page;
   assign base_page = range_base_field[mtrl_pkg::FIELD_MSB:mtrl_pkg::FIELD_LSB];
   assign mask_page = range_mask_field[mtrl_pkg::FIELD_MSB:mtrl_pkg::FIELD_LSB];
   // Pair ignored unless valid; compare masked base to masked address
   assign hit = range_mask_field[mtrl_pkg::VALID_BIT] &&
      ((mask_page & base_page) == (mask_page & page_addr));
   assign mem_type = range_base_field[2:0];
endmodule

// ===== verif/mtrl_lookup_assertions.sv
`timescale 1ns/1ps
module mtrl_lookup_assertions #(
   parameter int PHYS_ADDR_W = 52
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register access
   input wire logic reg_valid,
   input wire mtrl_pkg::mtrl_reg_req_s reg_req,
   input wire logic [63:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_fault,
   // Lookup
   input wire logic lookup_valid,
   input wire logic [51:0] lookup_addr,
   input wire logic result_valid,
   input wire mtrl_pkg::mtrl_result_s result
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic [51:0] am;
   wire unmapped = reg_req.index[4:2] == 3'h3;
   assign am = lookup_addr & ((52'h1 << PHYS_ADDR_W) - 52'h1);
   AST_REG_ANSWER: assert property (reg_valid |=> reg_rvalid)
      else $error("no register answer");
   AST_REG_QUIET: assert property (!reg_valid |=> !reg_rvalid && !reg_fault)
      else $error("answer without request");
   AST_FAULT: assert property (reg_valid && unmapped |=> reg_fault && reg_rdata == 64'h0)
      else $error("unmapped index not refused");
   AST_NO_FAULT: assert property (reg_valid && !unmapped |=> !reg_fault)
      else $error("mapped index refused");
   AST_WRITE_DATA: assert property (reg_valid && reg_req.write |=> reg_rdata == 64'h0)
      else $error("read data on write");
   AST_RDATA_IDLE: assert property (!reg_rvalid |-> reg_rdata == 64'h0)
      else $error("read data while idle");
   AST_LOOKUP_ONE: assert property (lookup_valid |=> result_valid)
      else $error("lookup answer late");
   AST_RESULT_IDLE: assert property (!result_valid |-> result == '0)
      else $error("result while idle");
   AST_FIXED_LOW: assert property (lookup_valid && |am[51:20] |=> !result.fixed_hit
      && !result.read_to_memory_attr && !result.write_to_memory_attr)
      else $error("fixed typing above first megabyte");
   cover property (reg_valid && unmapped);
   cover property (result_valid && result.fixed_hit);
   cover property (result_valid && result.var_hit);
endmodule

bind mtrl_lookup mtrl_lookup_assertions #(.PHYS_ADDR_W(PHYS_ADDR_W)) mtrl_lookup_assertions_i (
   .sys_clk, .reset_n, .reg_valid, .reg_req, .reg_rdata, .reg_rvalid, .reg_fault,
   .lookup_valid, .lookup_addr, .result_valid, .result
);

// ===== verif/mtrl_pipe_model.sv
`timescale 1ns/1ps
module mtrl_pipe_model (
   // Clock
   input wire logic sys_clk,
   // Command
   input wire logic req,
   input wire logic [51:0] req_addr,
   // Lookup request
   output logic lookup_valid = 1'b0,
   output logic [51:0] lookup_addr = '0
);
   // One strobe per command, idle address toggles
   always @(posedge sys_clk) begin
      lookup_valid <= req;
      lookup_addr <= req ? req_addr : ~lookup_addr;
   end
endmodule

// ===== verif/mtrl_lookup_bench.sv
`timescale 1ns/1ps
module mtrl_lookup_bench;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_valid = 1'b0;
   mtrl_pkg::mtrl_reg_req_s reg_req = '0;
   logic [63:0] reg_rdata;
   logic reg_rvalid, reg_fault, lookup_valid, result_valid;
   logic req = 1'b0;
   logic [51:0] req_addr = '0;
   logic [51:0] lookup_addr;
   logic [6:0] care = 7'h7F;
   mtrl_pkg::mtrl_result_s result;
   int bad_count = 0;
   int checked = 0;
   mtrl_lookup mtrl_lookup_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_valid(reg_valid),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_fault(reg_fault), .lookup_valid(lookup_valid), .lookup_addr(lookup_addr),
      .result_valid(result_valid), .result(result));
   mtrl_pipe_model mtrl_pipe_model_i (.sys_clk(sys_clk), .req(req), .req_addr(req_addr),
      .lookup_valid(lookup_valid), .lookup_addr(lookup_addr));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_res(input logic [6:0] exp);
      logic [6:0] g;
      g = result;
      checked++;
      if (result_valid !== 1'b1 || (g & care) !== (exp & care)) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, g, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [4:0] idx, input logic [63:0] d);
      @(posedge sys_clk) #1;
      reg_valid = 1'b1;
      reg_req = '{w, idx, d};
      @(posedge sys_clk) #1;
      reg_valid = 1'b0;
      chk64({63'h0, reg_rvalid}, 64'h1);
   endtask
   task automatic rd(input logic [4:0] idx, input logic [63:0] exp);
      acc(1'b0, idx, 64'h0);
      chk64(reg_rdata, exp);
   endtask
   task automatic look(input logic [51:0] a, input logic [6:0] exp);
      @(posedge sys_clk) #1;
      req = 1'b1;
      req_addr = a;
      @(posedge sys_clk) #1;
      req = 1'b0;
      @(posedge sys_clk) #1;
      chk_res(exp);
   endtask
   function automatic logic [4:0] fv(input int n);
      logic [2:0] t [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
      return {n[2:1], t[n % 5]};
   endfunction
   task automatic t_regs;
      rd(5'h0B, 64'h0);
      look(52'h2000_0000, 7'h00);
      acc(1'b1, 5'h0B, '1);
      rd(5'h0B, 64'hC07);
      acc(1'b1, 5'h03, '1);
      rd(5'h03, 64'h1F1F_1F1F_1F1F_1F1F);
      acc(1'b1, 5'h1E, '1);
      rd(5'h1E, 64'hF_FFFF_FFFF_F007);
      acc(1'b1, 5'h1F, '1);
      rd(5'h1F, 64'hF_FFFF_FFFF_F800);
      acc(1'b1, 5'h1F, 64'h0);
      acc(1'b1, 5'h0C, '1);
      chk64({63'h0, reg_fault}, 64'h1);
      chk64(reg_rdata, 64'h0);
   endtask
   task automatic t_fixed;
      logic [63:0] v;
      logic [4:0] f;
      logic [51:0] b, s;
      for (int i = 0; i < 11; i++) begin
         for (int k = 0; k < 8; k++) v[8*k+:8] = {3'h0, fv(i*8+k)};
         acc(1'b1, 5'(i), v);
      end
      acc(1'b1, 5'h0B, 64'hC06);
      for (int i = 0; i < 11; i++) begin
         s = i == 0 ? 52'h1_0000 : i < 3 ? 52'h4000 : 52'h1000;
         b = i == 0 ? 52'h0 : i < 3 ? 52'h6_0000 + 52'(i) * 52'h2_0000 :
            52'hA_8000 + 52'(i) * 52'h8000;
         for (int k = 0; k < 8; k++) begin
            f = fv(i*8+k);
            look(b + 52'(k) * s, {f[2:0], f[4:3], 2'b10});
            look(b + 52'(k+1) * s - 52'h1, {f[2:0], f[4:3], 2'b10});
         end
      end
   endtask
   task automatic t_off;
      acc(1'b1, 5'h0B, 64'h806);
      look(52'h1_0000, 7'h60);
      acc(1'b1, 5'h0B, 64'h406);
      look(52'h6_0000, 7'h0C);
      acc(1'b1, 5'h0B, 64'hC06);
   endtask
   task automatic t_var;
      // Power-of-two sizes on aligned bases
      acc(1'b1, 5'h10, 64'h200_0004);
      acc(1'b1, 5'h11, 64'hF_FFFF_FE00_0800);
      acc(1'b1, 5'h12, 64'h300_0006);
      acc(1'b1, 5'h13, 64'hF_FFFF_FF00_0800);
      look(52'h210_0000, 7'h41);
      look(52'h380_0000, 7'h41);
      look(52'h400_0000, 7'h60);
      acc(1'b1, 5'h14, 64'h380_0000);
      acc(1'b1, 5'h15, 64'hF_FFFF_FF80_0800);
      look(52'h380_0000, 7'h01);
      look(52'h300_0000, 7'h41);
      acc(1'b1, 5'h11, 64'hF_FFFF_FE00_0000);
      look(52'h210_0000, 7'h60);
      look(52'h300_0000, 7'h61);
      acc(1'b1, 5'h16, 64'h1);
      acc(1'b1, 5'h17, 64'hF_FFFF_FE00_0800);
      look(52'h2_0000, 7'h46);
      look(52'h10_0000, 7'h11);
      look(52'h1_0006_0000, 7'h60);
      acc(1'b1, 5'h11, 64'hF_FFFF_FE00_0800);
      acc(1'b1, 5'h16, 64'h200_0001);
      look(52'h210_0000, 7'h01);
   endtask
   task automatic test_done;
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #700000;
      bad_count++;
      test_done;
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      t_regs;
      t_fixed;
      t_off;
      t_var;
      test_done;
   end
endmodule
